/* File: rtl/pmdi_pkg.sv */
/*
  Shared constants and types for the PHY-side MAC data interface.
  Assumes a single 100 MHz system clock drives both ends.
*/
package pmdi_pkg;
  // Interface modes; fixed at reset by configuration.
  typedef enum logic [1:0] {
    PMDI_MODE_MII,
    PMDI_MODE_RMII,
    PMDI_MODE_SNI
  } pmdi_mode_e;

  localparam int SYS_CLK_MHZ = 100;
  localparam int REF_CLK_MHZ = 25;
  localparam int RMII_CLK_MHZ = 50;
  localparam int SNI_CLK_MHZ = 10;
  localparam int MII_CLK_100_KHZ = 25000;
  localparam int MII_CLK_10_KHZ = 2500;
  // Prescale step of the 10 Mb/s MII divider, in sys_clk cycles.
  localparam int MII_PRE_DIV = 10;
  // Cycles of sys_clk per link clock period.
  localparam int MII_DIV_100 = SYS_CLK_MHZ * 1000 / MII_CLK_100_KHZ;
  localparam int MII_DIV_10 = SYS_CLK_MHZ * 1000 / MII_CLK_10_KHZ;
  localparam int RMII_DIV = SYS_CLK_MHZ / RMII_CLK_MHZ;
  localparam int SNI_DIV = SYS_CLK_MHZ / SNI_CLK_MHZ;
  localparam int DIV_W = 6;
endpackage

/* File: rtl/pmdi_if.sv */
/*
  Interface joining the PHY end and the MAC end of the data interface.
  Assumes both ends run on the same sys_clk; link clocks are enable pulses.
*/
`timescale 1ns/1ps
interface pmdi_if;
  logic tx_clk;
  logic rx_clk;
  logic ref_stb;
  logic tx_en;
  logic [3:0] txd;
  logic rx_dv;
  logic rx_er;
  logic crs_dv;
  logic [3:0] rxd;

  modport phy (
    output tx_clk, rx_clk, ref_stb, rx_dv, rx_er, crs_dv, rxd,
    input tx_en, txd
  );
  modport mac (
    input tx_clk, rx_clk, ref_stb, rx_dv, rx_er, crs_dv, rxd,
    output tx_en, txd
  );
endinterface

/* File: rtl/pmdi_phy.sv */
/*
  PHY end of the MAC data interface: clock generation, transmit sampling,
  receive valid, error and carrier signalling for MII, RMII and SNI modes.
  Every link clock is a one-cycle strobe of sys_clk from one shared
  divider: four cycles per strobe for MII at 100 Mb/s, forty for MII at
  10 Mb/s, two for RMII and ten for SNI.
  The transmit pins are taken on the strobe cycle and show on tx_valid and
  tx_data one cycle later; receive indications change on the cycle after
  a strobe and stand until the next one.
  Assumes a line-side receive stream (valid, data, symbol error, false
  carrier) already on sys_clk, and a mode strap that is stable around
  reset, so neither passes a synchroniser here.
  Assumes the MAC end is set to the same mode and uses the same strobes.
*/
// Behaviour
// - MII transmit clock 25 or 2.5 MHz
// - RMII times everything from 50 MHz reference
// - SNI drives 10 MHz transmit clock
// - MAC holds transmit enable with valid data
// - MII samples nibbles on transmit clock
// - RMII samples two bits on reference
// - SNI samples one bit only
// - MII receive clock 25 or 2.5 MHz
// - SNI receive clock 10 MHz
// - MII receive valid marks valid nibbles
// - RMII also drives receive valid
// - SNI leaves valid and error unused
// - MII 100 Mb/s flags invalid symbols
// - RMII flags invalid symbol during carrier; here the PHY flags it at 100 Mb/s only
// - RMII flags false carrier too
// - RMII corrupts data on receive error
// - System supplies 50 MHz reference clock; here the PHY makes ref_stb from its sys_clk divider
// - SNI frames receive bit with carrier
`timescale 1ns/1ps
module pmdi_phy
  import pmdi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pmdi_mode_e mode_strap,
  input wire logic speed_100,
  input wire logic line_valid,
  input wire logic [3:0] line_data,
  input wire logic line_sym_err,
  input wire logic line_false_carrier,
  output logic tx_valid,
  output logic [3:0] tx_data,
  pmdi_if.phy link
);
  pmdi_mode_e mode_ff, nxt_mode;
  logic strap_done_ff, nxt_strap_done;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic tick;
  logic [DIV_W-1:0] div_max;
  logic [3:0] tx_data_ff, nxt_tx_data;
  logic tx_valid_ff, nxt_tx_valid;
  logic rx_dv_ff, nxt_rx_dv;
  logic rx_er_ff, nxt_rx_er;
  logic crs_dv_ff, nxt_crs_dv;
  logic [3:0] rxd_ff, nxt_rxd;

  // Divider period per mode and speed; one tick marks each link clock edge.
  function automatic logic [DIV_W-1:0] period(pmdi_mode_e m, logic fast);
    logic [DIV_W-1:0] p;
    p = DIV_W'(SNI_DIV);
    unique case (m)
      PMDI_MODE_MII: p = fast ? DIV_W'(MII_DIV_100) : DIV_W'(MII_DIV_10 / MII_PRE_DIV);
      PMDI_MODE_RMII: p = DIV_W'(RMII_DIV);
      PMDI_MODE_SNI: p = DIV_W'(SNI_DIV);
    endcase
    return p;
  endfunction

  // The 10 Mb/s MII rate needs a count of 40, held here as 4 tick groups
  // of ten so the divider stays narrow; a prescaler supplies the groups.
  logic [3:0] pre_ff, nxt_pre;
  logic pre_tick;
  // Last prescaler count; the prescaler only advances in MII at 10 Mb/s.
  localparam logic [3:0] PRE_LAST = 4'(MII_PRE_DIV - 1);

  // Mode is caught once after reset release, so a moving strap is ignored.
  always_comb begin
    nxt_mode = mode_ff;
    nxt_strap_done = 1'b1;
    if (!strap_done_ff) begin
      nxt_mode = mode_strap;
    end
  end

  // Link clock divider: 25/2.5 MHz for MII, 50 MHz for RMII, 10 MHz for SNI.
  // Limitation: speed_100 is read live, so the first strobe period after a
  // change of speed may be short; the MAC should only change speed while
  // the link is idle.
  always_comb begin
    div_max = period(mode_ff, speed_100) - DIV_W'(1);
    pre_tick = (mode_ff != PMDI_MODE_MII) || speed_100 || (pre_ff == PRE_LAST);
    nxt_pre = pre_tick ? 4'd0 : pre_ff + 4'd1;
    nxt_div = div_ff;
    tick = 1'b0;
    if (pre_tick) begin
      if (div_ff == div_max) begin
        nxt_div = '0;
        tick = 1'b1;
      end else begin
        nxt_div = div_ff + DIV_W'(1);
      end
    end
  end

  // Transmit sampling on the link clock tick; unused data lines are masked.
  // Masking keeps spare pins that a MAC leaves floating out of the sampled
  // word, at the cost of never seeing them for diagnostics.
  always_comb begin
    nxt_tx_data = tx_data_ff;
    nxt_tx_valid = tx_valid_ff;
    if (tick) begin
      nxt_tx_valid = link.tx_en;
      unique case (mode_ff)
        PMDI_MODE_MII: nxt_tx_data = link.txd;
        PMDI_MODE_RMII: nxt_tx_data = {2'b00, link.txd[1:0]};
        PMDI_MODE_SNI: nxt_tx_data = {3'b000, link.txd[0]};
      endcase
    end
  end

  // Receive indications, updated on the same link clock tick.
  always_comb begin
    nxt_rx_dv = rx_dv_ff;
    nxt_rx_er = rx_er_ff;
    nxt_crs_dv = crs_dv_ff;
    nxt_rxd = rxd_ff;
    if (tick) begin
      unique case (mode_ff)
        PMDI_MODE_MII: begin
          nxt_rx_dv = line_valid;
          nxt_rx_er = speed_100 && line_valid && line_sym_err;
          nxt_crs_dv = line_valid;
          // Data is zeroed outside a frame so that idle line noise never
          // reaches the MAC as a plausible nibble.
          nxt_rxd = line_valid ? line_data : 4'd0;
        end
        PMDI_MODE_RMII: begin
          nxt_rx_dv = line_valid;
          // The combined carrier and valid pin also rises on a false carrier.
          nxt_crs_dv = line_valid || line_false_carrier;
          nxt_rx_er = (speed_100 && line_valid && line_sym_err)
                      || line_false_carrier;
          // Corrupted dibit lets a MAC that ignores the error flag still
          // fail its checksum.
          nxt_rxd = (line_sym_err || line_false_carrier) ? 4'b0010
                    : {2'b00, line_data[1:0]};
        end
        PMDI_MODE_SNI: begin
          // Valid and error are held low rather than frozen, so a port set
          // to serial mode never shows a stale error from an earlier frame.
          nxt_rx_dv = 1'b0;
          nxt_rx_er = 1'b0;
          nxt_crs_dv = line_valid;
          nxt_rxd = {3'b000, line_valid & line_data[0]};
        end
      endcase
    end
  end

  // State registers. The reset branch loads constants only; the strap is
  // caught on the first edge after release instead.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= PMDI_MODE_MII;
      strap_done_ff <= 1'b0;
      div_ff <= '0;
      pre_ff <= 4'd0;
      tx_data_ff <= 4'd0;
      tx_valid_ff <= 1'b0;
      rx_dv_ff <= 1'b0;
      rx_er_ff <= 1'b0;
      crs_dv_ff <= 1'b0;
      rxd_ff <= 4'd0;
    end else begin
      mode_ff <= nxt_mode;
      strap_done_ff <= nxt_strap_done;
      div_ff <= nxt_div;
      pre_ff <= nxt_pre;
      tx_data_ff <= nxt_tx_data;
      tx_valid_ff <= nxt_tx_valid;
      rx_dv_ff <= nxt_rx_dv;
      rx_er_ff <= nxt_rx_er;
      crs_dv_ff <= nxt_crs_dv;
      rxd_ff <= nxt_rxd;
    end
  end

  // Clock strobes: MII and SNI use tx/rx clocks, RMII only the reference.
  // They are combinational from the divider so that both ends see the tick
  // in the same cycle; a registered copy would put the MAC a cycle late.
  assign link.tx_clk = tick && (mode_ff != PMDI_MODE_RMII);
  assign link.rx_clk = tick && (mode_ff != PMDI_MODE_RMII);
  assign link.ref_stb = tick && (mode_ff == PMDI_MODE_RMII);
  assign link.rx_dv = rx_dv_ff;
  assign link.rx_er = rx_er_ff;
  assign link.crs_dv = crs_dv_ff;
  assign link.rxd = rxd_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
endmodule

/* File: rtl/pmdi_mac.sv */
/*
  MAC end of the data interface: drives transmit enable and data on the
  PHY's clock strobe and gathers receive data.
  Assumes the user holds frame data until tx_ready and uses the same mode.
*/
`timescale 1ns/1ps
module pmdi_mac
  import pmdi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pmdi_mode_e mode,
  input wire logic tx_req,
  input wire logic [3:0] tx_word,
  output logic tx_ready,
  output logic rx_valid,
  output logic rx_err,
  output logic [3:0] rx_word,
  pmdi_if.mac link
);
  logic tx_en_ff, nxt_tx_en;
  logic [3:0] txd_ff, nxt_txd;
  logic rx_valid_ff, nxt_rx_valid;
  logic rx_err_ff, nxt_rx_err;
  logic [3:0] rx_word_ff, nxt_rx_word;
  logic tstb;
  logic rstb;

  // RMII transfers ride on the reference strobe, others on the link clocks.
  assign tstb = (mode == PMDI_MODE_RMII) ? link.ref_stb : link.tx_clk;
  assign rstb = (mode == PMDI_MODE_RMII) ? link.ref_stb : link.rx_clk;

  // Transmit: enable stays high exactly while a valid word is presented.
  always_comb begin
    nxt_tx_en = tx_en_ff;
    nxt_txd = txd_ff;
    if (tstb) begin
      nxt_tx_en = tx_req;
      nxt_txd = tx_req ? tx_word : 4'd0;
    end
  end

  // Receive: carrier frames data; the error flag is kept for diagnostics.
  always_comb begin
    nxt_rx_valid = 1'b0;
    nxt_rx_err = rx_err_ff;
    nxt_rx_word = rx_word_ff;
    if (rstb) begin
      nxt_rx_valid = link.crs_dv;
      nxt_rx_err = link.rx_er;
      nxt_rx_word = link.rxd;
    end
  end

  // State registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_ff <= 1'b0;
      txd_ff <= 4'd0;
      rx_valid_ff <= 1'b0;
      rx_err_ff <= 1'b0;
      rx_word_ff <= 4'd0;
    end else begin
      tx_en_ff <= nxt_tx_en;
      txd_ff <= nxt_txd;
      rx_valid_ff <= nxt_rx_valid;
      rx_err_ff <= nxt_rx_err;
      rx_word_ff <= nxt_rx_word;
    end
  end

  assign tx_ready = tstb;
  assign link.tx_en = tx_en_ff;
  assign link.txd = txd_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_err = rx_err_ff;
  assign rx_word = rx_word_ff;
endmodule

/* File: verif/pmdi_assertions.sv */
/*
  Link timing and status checks for the PHY-MAC data interface.
  Assumes one sys_clk and that the strap changes only while in reset.
*/
`timescale 1ns/1ps
module pmdi_assertions
  import pmdi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pmdi_mode_e mode_strap,
  input wire logic speed_100,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic ref_stb,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Mode decodes; the strap is stable once reset is released.
  wire mii = mode_strap == PMDI_MODE_MII;
  wire rmii = mode_strap == PMDI_MODE_RMII;
  wire sni = mode_strap == PMDI_MODE_SNI;
  a_mii_fast_tx: assert property (mii && speed_100 && tx_clk |=> !tx_clk [*3] ##1 tx_clk)
    else $error("fast transmit strobe period wrong");
  a_mii_slow_tx: assert property (mii && !speed_100 && tx_clk |-> ##40 tx_clk)
    else $error("slow transmit strobe period wrong");
  a_mii_fast_rx: assert property (mii && speed_100 && rx_clk |-> ##4 rx_clk)
    else $error("fast receive strobe period wrong");
  a_rmii_no_clk: assert property (rmii |-> !tx_clk && !rx_clk)
    else $error("link strobes active in reduced mode");
  a_rmii_ref_rate: assert property (rmii && ref_stb |=> !ref_stb ##1 ref_stb)
    else $error("reference strobe period wrong");
  a_sni_tx_rate: assert property (sni && tx_clk |=> !tx_clk [*8] ##1 !tx_clk ##1 tx_clk)
    else $error("serial transmit strobe period wrong");
  a_sni_rx_rate: assert property (sni && rx_clk |-> ##10 rx_clk)
    else $error("serial receive strobe period wrong");
  a_sni_no_status: assert property (sni |-> !rx_dv && !rx_er)
    else $error("valid or error driven in serial mode");
  a_rmii_err_data: assert property (rmii && rx_er |-> rxd == 4'h2)
    else $error("receive data not corrupted on error");
  a_slow_no_err: assert property (mii && !speed_100 |-> !rx_er)
    else $error("receive error raised at 10 Mb/s");
endmodule

/* File: verif/tb_top.sv */
/*
  Self-checking bench: both ends face each other; user sides are driven.
  Assumes strobe-paced transfers and a mode caught just after reset.
*/
`timescale 1ns/1ps
module tb_top;
  import pmdi_pkg::*;
  logic sys_clk, rst_n, speed_100, line_valid, line_sym_err, tx_req, st_d;
  logic tx_valid, tx_ready, rx_valid, rx_err, er_exp, dv_exp, line_fc;
  logic [3:0] line_data, tx_word, tx_data, rx_word, rx_exp, mask;
  pmdi_mode_e mode;
  logic [3:0] exp_q[$];
  int mismatches, num_checks;
  pmdi_if pmdi_if_i();
  pmdi_phy pmdi_phy_i(.sys_clk(sys_clk), .rst_n(rst_n), .mode_strap(mode),
    .speed_100(speed_100), .line_valid(line_valid), .line_data(line_data),
    .line_sym_err(line_sym_err), .line_false_carrier(line_fc), .tx_valid(tx_valid),
    .tx_data(tx_data), .link(pmdi_if_i));
  pmdi_mac pmdi_mac_i(.sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .tx_req(tx_req),
    .tx_word(tx_word), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_err(rx_err),
    .rx_word(rx_word), .link(pmdi_if_i));
  pmdi_assertions pmdi_assertions_i(.sys_clk(sys_clk), .rst_n(rst_n), .mode_strap(mode),
    .speed_100(speed_100), .tx_clk(pmdi_if_i.tx_clk), .rx_clk(pmdi_if_i.rx_clk),
    .ref_stb(pmdi_if_i.ref_stb), .rx_dv(pmdi_if_i.rx_dv), .rx_er(pmdi_if_i.rx_er),
    .rxd(pmdi_if_i.rxd));
  // Lanes that carry data in each mode; the rest must read as zero.
  assign mask = mode == PMDI_MODE_MII ? 4'hf : mode == PMDI_MODE_RMII ? 4'h3 : 4'h1;
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One mode per reset; the strap only moves while reset is held.
  task automatic run_mode(input pmdi_mode_e m, input logic spd, input logic err,
      input logic fc, input int n);
    int k;
    rst_n = 0;
    mode = m;
    speed_100 = spd;
    line_sym_err = err;
    line_fc = fc;
    line_valid = 1;
    line_data = 4'($urandom);
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1;
    // Only RMII corrupts data; MII flags symbol errors at 100 Mb/s only.
    rx_exp = (m == PMDI_MODE_RMII && (err || fc)) ? 4'h2 : line_data & mask;
    er_exp = (m == PMDI_MODE_MII && spd && err)
             || (m == PMDI_MODE_RMII && ((spd && err) || fc));
    dv_exp = m != PMDI_MODE_SNI;
    for (k = 0; k < n; k++) begin
      tx_req = 1;
      tx_word = 4'($urandom);
      do @(negedge sys_clk); while (tx_ready !== 1'b1);
      exp_q.push_back(tx_word & mask);
      @(posedge sys_clk);
      #1;
    end
    tx_req = 0;
    repeat (100) @(posedge sys_clk);
    #1 chk({3'b000, exp_q.size() != 0}, 4'h0);
  endtask
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Marks the cycle after a sampling strobe, when tx_valid and tx_data renew.
  always @(posedge sys_clk) st_d <= pmdi_if_i.tx_clk | pmdi_if_i.ref_stb;
  // Settled values are compared mid-cycle so no edge race can decide them.
  always @(negedge sys_clk) begin
    if (rst_n && st_d && tx_valid === 1'b1 && exp_q.size() > 0)
      chk(tx_data, exp_q.pop_front());
    if (rst_n && rx_valid === 1'b1) begin
      chk(rx_word, rx_exp);
      chk({3'b000, rx_err}, {3'b000, er_exp});
      chk({3'b000, pmdi_if_i.rx_dv}, {3'b000, dv_exp});
    end
  end
  // The whole run needs about 1100 cycles; a hang is cut at 20000, about eighteen times that.
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h361a_d6ce));
    rst_n = 0;
    mode = PMDI_MODE_MII;
    {speed_100, line_valid, line_sym_err, tx_req} = 4'h0;
    line_fc = 1'b0;
    line_data = 4'h0;
    tx_word = 4'h0;
    mismatches = 0;
    num_checks = 0;
    #1;
    run_mode(PMDI_MODE_MII, 1'b1, 1'b1, 1'b0, 20);
    run_mode(PMDI_MODE_MII, 1'b0, 1'b1, 1'b0, 6);
    run_mode(PMDI_MODE_RMII, 1'b1, 1'b0, 1'b0, 20);
    run_mode(PMDI_MODE_RMII, 1'b1, 1'b1, 1'b0, 10);
    run_mode(PMDI_MODE_RMII, 1'b0, 1'b0, 1'b1, 10);
    run_mode(PMDI_MODE_SNI, 1'b0, 1'b0, 1'b0, 10);
    give_verdict();
  end
endmodule
